// File: shared/pcc_map.svh
// Offsets, field positions, reset values and codes of the PCM serial port.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define PCC_OFF_XMIT_WORD 8'h00
`define PCC_OFF_RECV_WORD 8'h04
`define PCC_OFF_STATUS    8'h08
`define PCC_OFF_DC_OFFSET 8'h0c

// ---------------------------------------------------------------
// Status field positions
// ---------------------------------------------------------------
`define PCC_ST_RX_FULL 0
`define PCC_ST_ALAW    1
`define PCC_ST_TX_STBY 2
`define PCC_ST_RX_STBY 3
`define PCC_ST_PDOWN   4

// ---------------------------------------------------------------
// Reset values, word shape and codes
// ---------------------------------------------------------------
`define PCC_XMIT_WORD_RST 8'hff
`define PCC_RECV_WORD_RST 8'hff
`define PCC_DC_RST        16'h0000
`define PCC_DC_MAX        16'h7fff
`define PCC_DC_MIN        16'h8000
`define PCC_ALAW_MASK     8'h55
`define PCC_WORD_BITS     8
`define PCC_RESP_OKAY     2'b00
`define PCC_RESP_SLVERR   2'b10

`endif

// File: shared/pcc_pkg.sv
// Types shared by the PCM serial port files.
// Assumes nothing of its surroundings.
`default_nettype none

package pcc_pkg;

	// Transmit slot state
	typedef enum logic
	{
		PCC_TX_IDLE,
		PCC_TX_SHIFT
	} pcc_tx_state_t;

endpackage : pcc_pkg

`default_nettype wire

// File: rtl/pcc_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to aclk; output is safe to use.
`default_nettype none

module pcc_sync
	import pcc_pkg::*;
#(
	parameter int WIDTH = 1
)(
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta; // First stage, read only by second

	// ---------------------------------------------------------------
	// Two stages per bit
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta     <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule : pcc_sync

`default_nettype wire

// File: rtl/pcc_serial_port.sv
// Variable-rate PCM serial port of a telephone codec, with AXI4-Lite registers.
// Assumes bit clocks far slower than aclk (at least 4 aclk per half period).
`include "pcc_map.svh"
`default_nettype none

module pcc_serial_port
	import pcc_pkg::*;
#(
	parameter int ADDR_W = 8
)(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Transmit highway pins
	input  wire logic              xmit_bit_clock,
	input  wire logic              xmit_frame_sync,
	output logic                   pcm_out,
	output logic                   pcm_out_oe,
	output logic                   xmit_slot_strobe_n,
	output logic                   xmit_slot_strobe_oe,
	// Receive highway pins
	input  wire logic              recv_bit_clock,
	input  wire logic              recv_frame_sync,
	input  wire logic              pcm_in,
	// Static pins
	input  wire logic              companding_law_select,
	input  wire logic              power_down_n
);

	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	logic [6:0] pin_s;        // Synchronised pin levels
	logic       xbc, xfs;     // Transmit clock and sync
	logic       rbc, rfs;     // Receive clock and sync
	logic       din, law, pd; // Data in, law pin, power-down_n
	logic       xbc_q, xfs_q; // Previous transmit levels
	logic       rbc_q, rfs_q; // Previous receive levels

	pcc_sync #(.WIDTH(7)) u_sync
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({xmit_bit_clock, xmit_frame_sync, recv_bit_clock,
		            recv_frame_sync, pcm_in, companding_law_select, power_down_n}),
		.sync_out (pin_s)
	);

	assign {xbc, xfs, rbc, rfs, din, law, pd} = pin_s;

	// Edge history; clock and data share one pipeline so they stay aligned
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{xbc_q, xfs_q, rbc_q, rfs_q} <= 4'h0;
		end
		else
		begin
			{xbc_q, xfs_q, rbc_q, rfs_q} <= {xbc, xfs, rbc, rfs};
		end
	end

	logic xbc_rise, xbc_fall, xfs_rise, rbc_fall, rfs_rise;
	logic [7:0] law_mask; // A-law inverts even bits on the line

	assign xbc_rise = xbc & ~xbc_q;
	assign xbc_fall = ~xbc & xbc_q;
	assign xfs_rise = xfs & ~xfs_q;
	assign rbc_fall = ~rbc & rbc_q;
	assign rfs_rise = rfs & ~rfs_q;
	assign law_mask = law ? 8'h00 : `PCC_ALAW_MASK;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [7:0]        xmit_word;  // Next sample from software
	logic [7:0]        recv_word;  // Last word taken from highway
	logic              rx_full;    // Sticky new-word flag
	logic signed [15:0] dc_acc;    // Running sign-bit average
	logic [ADDR_W-1:0] aw_addr;    // Held write address
	logic [31:0]       w_data;     // Held write data
	logic [3:0]        w_strb;     // Held byte enables
	logic              aw_have;    // Address held
	logic              w_have;     // Data held
	logic              wr_fire;    // Write performed this cycle
	logic              rx_done;    // Receive word complete pulse
	logic [7:0]        rx_shift;   // Receive shifter

	assign wr_fire = aw_have & w_have & ~s_axi_bvalid;

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	// Address and data taken in either order; response after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PCC_RESP_OKAY;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr       <= s_axi_awaddr;
				aw_have       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_have       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Only the two writable offsets answer OKAY
				if (aw_addr == `PCC_OFF_XMIT_WORD || aw_addr == `PCC_OFF_STATUS)
					s_axi_bresp <= `PCC_RESP_OKAY;
				else
					s_axi_bresp <= `PCC_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	logic [31:0] next_rdata; // Read mux result
	logic [1:0]  next_rresp; // Read answer code

	// Read mux; unmapped offsets read zero with SLVERR
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_rresp = `PCC_RESP_OKAY;
		case (s_axi_araddr)
			`PCC_OFF_XMIT_WORD: next_rdata[7:0] = xmit_word;
			`PCC_OFF_RECV_WORD: next_rdata[7:0] = recv_word;
			`PCC_OFF_STATUS:
			begin
				next_rdata[`PCC_ST_RX_FULL] = rx_full;
				next_rdata[`PCC_ST_ALAW]    = ~law;
				next_rdata[`PCC_ST_TX_STBY] = ~xfs;
				next_rdata[`PCC_ST_RX_STBY] = ~rfs;
				next_rdata[`PCC_ST_PDOWN]   = ~pd;
			end
			`PCC_OFF_DC_OFFSET: next_rdata[15:0] = dc_acc;
			default: next_rresp = `PCC_RESP_SLVERR;
		endcase
	end

	// One read at a time, answered the cycle after it is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PCC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	// Sample to send; taken by the transmitter at each frame start
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			xmit_word <= `PCC_XMIT_WORD_RST;
		else if (wr_fire && aw_addr == `PCC_OFF_XMIT_WORD && w_strb[0])
			xmit_word <= w_data[7:0];
	end

	// Received word and its flag; a new word beats a write-one clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			recv_word <= `PCC_RECV_WORD_RST;
			rx_full   <= 1'b0;
		end
		else if (rx_done)
		begin
			recv_word <= rx_shift ^ law_mask;
			rx_full   <= 1'b1;
		end
		else if (wr_fire && aw_addr == `PCC_OFF_STATUS && w_strb[0]
		         && w_data[`PCC_ST_RX_FULL])
			rx_full <= 1'b0;
	end

	// Sign bit average: up on positive, down on negative, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dc_acc <= `PCC_DC_RST;
		else if (xfs_rise && pd)
		begin
			if (xmit_word[7] && dc_acc != `PCC_DC_MAX)
				dc_acc <= dc_acc + 16'sd1;
			else if (!xmit_word[7] && dc_acc != `PCC_DC_MIN)
				dc_acc <= dc_acc - 16'sd1;
		end
	end

	// ---------------------------------------------------------------
	// Transmit channel
	// ---------------------------------------------------------------
	pcc_tx_state_t tx_state;  // Slot state
	logic [7:0]    tx_word;   // Word held for this frame
	logic [2:0]    tx_cnt;    // Bit index, wraps for repeats
	logic [7:0]    cur_word;  // Word seen by this edge
	logic [2:0]    cur_cnt;   // Index seen by this edge

	// A frame start in the same cycle as a clock edge uses the new word
	assign cur_word = xfs_rise ? (xmit_word ^ law_mask) : tx_word;
	assign cur_cnt  = xfs_rise ? 3'd0 : tx_cnt;

	// Fixed-rate signaling has no place here: plain eight-bit words only
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !pd)
		begin
			tx_state            <= PCC_TX_IDLE;
			tx_word             <= `PCC_XMIT_WORD_RST;
			tx_cnt              <= 3'd0;
			pcm_out             <= 1'b0;
			pcm_out_oe          <= 1'b0;
			xmit_slot_strobe_n  <= 1'b1;
			xmit_slot_strobe_oe <= 1'b0;
		end
		else
		begin
			if (xfs_rise)
			begin
				tx_word  <= xmit_word ^ law_mask;
				tx_cnt   <= 3'd0;
				tx_state <= PCC_TX_SHIFT;
			end
			if (xfs && xbc_rise && (tx_state == PCC_TX_SHIFT || xfs_rise))
			begin
				// MSB (sign) first; the 3-bit index wraps to repeat
				pcm_out             <= cur_word[3'd7 - cur_cnt];
				tx_cnt              <= cur_cnt + 3'd1;
				pcm_out_oe          <= 1'b1;
				xmit_slot_strobe_n  <= 1'b0;
				xmit_slot_strobe_oe <= 1'b1;
			end
			// Last bit held through its falling edge, then released
			if (!xfs && xbc_fall)
			begin
				tx_state            <= PCC_TX_IDLE;
				pcm_out_oe          <= 1'b0;
				xmit_slot_strobe_n  <= 1'b1;
				xmit_slot_strobe_oe <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Receive channel, independent of the transmit side
	// ---------------------------------------------------------------
	logic [3:0] rx_cnt;  // Bits taken this frame
	logic [3:0] rx_cur;  // Count seen by this edge

	assign rx_cur = rfs_rise ? 4'd0 : rx_cnt;

	// Only the first eight falling edges after sync rise are taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !pd)
		begin
			rx_cnt   <= 4'(`PCC_WORD_BITS); // Idle until a frame starts
			rx_shift <= 8'h00;
			rx_done  <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			if (rfs_rise)
				rx_cnt <= 4'd0;
			if (rfs && rbc_fall && rx_cur < 4'(`PCC_WORD_BITS))
			begin
				rx_shift <= {rx_shift[6:0], din};
				rx_cnt   <= rx_cur + 4'd1;
				rx_done  <= (rx_cur == 4'd7);
			end
		end
	end

endmodule : pcc_serial_port

`default_nettype wire

// File: verification/pcc_serial_port_properties.sv
// Checker for the PCM serial port: bus handshakes and transmit slot pins.
// Bound to pcc_serial_port and sees only its ports.
`default_nettype none

module pcc_serial_port_properties (
	// Clock and reset
	input wire logic		aclk,
	input wire logic		aresetn,
	// Register bus
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_bready,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic		s_axi_rvalid,
	input wire logic		s_axi_rready,
	// Transmit highway
	input wire logic		xmit_bit_clock,
	input wire logic		xmit_frame_sync,
	input wire logic		pcm_out,
	input wire logic		pcm_out_oe,
	input wire logic		xmit_slot_strobe_n,
	input wire logic		xmit_slot_strobe_oe,
	input wire logic		power_down_n
);
	// ----
	// Properties, one clock domain
	// ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both halves of a write taken in one cycle
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Bit clock falls with no slot requested
	sequence s_idle_fall;
		!xmit_frame_sync && $fell(xmit_bit_clock);
	endsequence
	AST_B_AFTER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_SLOT_PAIR: assert property (pcm_out_oe == xmit_slot_strobe_oe && xmit_slot_strobe_n == !pcm_out_oe)
		else $error("strobe and data enable disagree");
	AST_PDOWN: assert property (!power_down_n [*4] |-> !pcm_out_oe && !xmit_slot_strobe_oe)
		else $error("output driven in power down");
	AST_STBY: assert property (s_idle_fall |-> ##[1:6] !pcm_out_oe)
		else $error("output driven in standby");
	AST_START: assert property ($rose(xmit_bit_clock) && xmit_frame_sync && power_down_n |-> ##[2:6] pcm_out_oe)
		else $error("slot not driven");
	AST_HOLD_BIT: assert property ((pcm_out_oe && !xmit_bit_clock) [*3] |-> $stable(pcm_out))
		else $error("bit changed between rising edges");
endmodule : pcc_serial_port_properties

bind pcc_serial_port pcc_serial_port_properties i_pcc_serial_port_properties (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.xmit_bit_clock, .xmit_frame_sync, .pcm_out, .pcm_out_oe, .xmit_slot_strobe_n,
	.xmit_slot_strobe_oe, .power_down_n);

`default_nettype wire

// File: verification/pcc_highway_model.sv
// Highway controller model: bit clocks, frame syncs and serial data.
// Clocks run only inside frames; timing in ns, unrelated to aclk.
`default_nettype none

module pcc_highway_model (
	// Transmit side
	output var logic		xmit_bit_clock,
	output var logic		xmit_frame_sync,
	input wire logic		pcm_out,
	input wire logic		pcm_out_oe,
	// Receive side
	output var logic		recv_bit_clock,
	output var logic		recv_frame_sync,
	output var logic		pcm_in,
	// Captured words
	output var logic [7:0]	cap_byte,
	output var logic		cap_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Frames
	// ----
	// Idle highway, clocks still; receive clock never tied low for fixed rate
	initial
	begin
		{xmit_bit_clock, xmit_frame_sync, recv_bit_clock, recv_frame_sync} = 4'h0;
		pcm_in = 1'b0;
		cap_valid = 1'b0;
		cap_byte = 8'h00;
	end
	// Sync leads the clock, drops in last high phase
	task automatic tx_frame(input int nb, input bit cap);
		// Keep pin changes off the aclk edges
		#10;
		xmit_frame_sync = 1'b1;
		#130;
		for (int i = 0; i < nb; i++)
		begin
			xmit_bit_clock = 1'b1;
			#300;
			if (i == nb - 1)
				xmit_frame_sync = 1'b0;
			#100;
			xmit_bit_clock = 1'b0;
			#150;
			// Floating pin captured as unknown
			cap_byte = {cap_byte[6:0], pcm_out_oe ? pcm_out : 1'bx};
			cap_valid = cap && (i % 8 == 7);
			#250;
			cap_valid = 1'b0;
		end
	endtask : tx_frame
	// One word MSB first, data moved on rising edges
	task automatic rx_frame(input logic [7:0] d);
		#10;
		recv_frame_sync = 1'b1;
		#170;
		for (int i = 7; i >= 0; i--)
		begin
			pcm_in = d[i];
			recv_bit_clock = 1'b1;
			#400;
			recv_bit_clock = 1'b0;
			#400;
		end
		recv_frame_sync = 1'b0;
		// Released line shows the inverse of its last bit
		pcm_in = ~pcm_in;
	endtask : rx_frame
endmodule : pcc_highway_model

`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench of the PCM serial port.
// Drives AXI4-Lite and the highway model; queued notes checked by monitors.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic			aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic			s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic			s_axi_bvalid, s_axi_arready, s_axi_rvalid, cap_valid;
	logic [7:0]		s_axi_awaddr, s_axi_araddr, cap_byte, w, r, m;
	logic [31:0]	s_axi_wdata, s_axi_rdata;
	logic [3:0]		s_axi_wstrb;
	logic [1:0]		s_axi_bresp, s_axi_rresp;
	logic			xmit_bit_clock, xmit_frame_sync, recv_bit_clock, recv_frame_sync;
	logic			pcm_in, pcm_out, pcm_out_oe, xmit_slot_strobe_n, xmit_slot_strobe_oe;
	logic			companding_law_select, power_down_n;
	logic [15:0]	dc;
	logic [33:0]	exp_r[$];
	logic [1:0]		exp_b[$];
	logic [7:0]		exp_t[$];
	int				error_cnt, total_checks;
	// ----
	// Design and far side
	// ----
	pcc_serial_port #(.ADDR_W(8)) i_pcc_serial_port (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .xmit_bit_clock, .xmit_frame_sync, .pcm_out, .pcm_out_oe,
		.xmit_slot_strobe_n, .xmit_slot_strobe_oe, .recv_bit_clock, .recv_frame_sync,
		.pcm_in, .companding_law_select, .power_down_n);
	pcc_highway_model i_pcc_highway_model (.xmit_bit_clock, .xmit_frame_sync, .pcm_out,
		.pcm_out_oe, .recv_bit_clock, .recv_frame_sync, .pcm_in, .cap_byte, .cap_valid);
	// 10 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Write; address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		exp_b.push_back(e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		// Each channel released at its own ready
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [33:0] e);
		exp_r.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : axr
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// ----
	// Monitors and watchdog
	// ----
	// Bus answers against the oldest note
	always @(posedge aclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			chk({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
	end
	always @(posedge cap_valid)
		chk({26'h0, cap_byte}, {26'h0, exp_t.pop_front()});
	// Run needs well under 100 us
	initial
	begin
		#2000000;
		error_cnt++;
		$display("CHECK FAILED at %0t: timeout", $time);
		print_verdict();
	end
	// ----
	// Tests
	// ----
	initial
	begin
		void'($urandom(85));
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0;
		{companding_law_select, power_down_n, aresetn} = 3'h6;
		{error_cnt, total_checks, dc} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		// Reset values, read-only, masked write, unmapped
		axr(8'h00, {2'b00, 32'hff});
		axr(8'h04, {2'b00, 32'hff});
		axr(8'h0c, {2'b00, 32'h0});
		axr(8'h08, {2'b00, 32'h0c});
		axw(8'h04, 32'h12, 4'h1, 2'b10);
		axw(8'h00, 32'h34, 4'h0, 2'b00);
		axr(8'h00, {2'b00, 32'hff});
		axr(8'h10, {2'b10, 32'h0});
		$display("test registers done");
		// Both laws, word repeated in a long slot
		for (int l = 0; l < 2; l++)
		begin
			@(posedge aclk);
			companding_law_select <= l[0];
			w = 8'($urandom);
			m = l ? 8'h00 : 8'h55;
			dc = dc + (w[7] ? 16'h1 : 16'hffff);
			axw(8'h00, {24'h0, w}, 4'h1, 2'b00);
			axr(8'h08, {2'b00, 28'h0, 2'b11, ~l[0], 1'b0});
			exp_t.push_back(w ^ m);
			exp_t.push_back(w ^ m);
			i_pcc_highway_model.tx_frame(16, 1);
		end
		$display("test transmit done");
		// Mid-frame write waits a frame; receive runs alongside
		w = 8'($urandom);
		r = 8'($urandom);
		axw(8'h00, {24'h0, w}, 4'h1, 2'b00);
		exp_t.push_back(w);
		fork
			i_pcc_highway_model.tx_frame(8, 1);
			i_pcc_highway_model.rx_frame(r);
			begin
				#3000;
				axw(8'h00, {24'h0, ~w}, 4'h1, 2'b00);
			end
		join
		exp_t.push_back(~w);
		i_pcc_highway_model.tx_frame(8, 1);
		axr(8'h04, {2'b00, 24'h0, r});
		axr(8'h08, {2'b00, 32'h0d});
		axw(8'h08, 32'h1, 4'h1, 2'b00);
		axr(8'h08, {2'b00, 32'h0c});
		axr(8'h0c, {2'b00, 16'h0, dc});
		$display("test latency and receive done");
		// Power down in mid-slot
		fork
			i_pcc_highway_model.tx_frame(16, 0);
			begin
				@(negedge xmit_bit_clock);
				@(posedge aclk);
				power_down_n <= 1'b0;
				repeat (3) @(posedge aclk);
				axr(8'h08, {2'b00, 32'h18});
			end
		join
		@(posedge aclk);
		power_down_n <= 1'b1;
		repeat (10) @(posedge aclk);
		$display("test power down done");
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
